// ### pwr_mode_pkg.sv
// Purpose: Shared constants and types for the power-mode controller
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses

package pwr_mode_pkg;

	typedef enum logic [1:0] {
		MODE_SAMPLE,
		MODE_RUN,
		MODE_SLEEP
	} pmode_t;

	localparam logic [7:0] OFF_WAKE_CFG   = 8'h00;
	localparam logic [7:0] OFF_THR_PARAM  = 8'h04;
	localparam logic [7:0] OFF_GAIN_CAL   = 8'h08;
	localparam logic [7:0] OFF_SAMPLE_INTERVAL_COUNT    = 8'h0C;
	localparam logic [7:0] OFF_SLEEP_V    = 8'h10;
	localparam logic [7:0] OFF_NULL_CURR  = 8'h14;
	localparam logic [7:0] OFF_PERSIST    = 8'h18;
	localparam logic [7:0] OFF_CURR_ERR   = 8'h1C;
	localparam logic [7:0] OFF_SD_ERR     = 8'h20;
	localparam logic [7:0] OFF_OWN_DRAIN  = 8'h24;
	localparam logic [7:0] OFF_SD_PCT     = 8'h28;
	localparam logic [7:0] OFF_FCC        = 8'h2C;
	localparam logic [7:0] OFF_STATUS     = 8'h30;
	localparam logic [7:0] OFF_CAPACITY   = 8'h34;
	localparam logic [7:0] OFF_MAX_ERROR  = 8'h38;

	localparam int WAKE_PIN_BIT  = 6;
	localparam int WAKE_BUS_BIT  = 5;
	localparam int WAKE_CURR_BIT = 4;
	localparam int WAKE_VOLT_BIT = 3;

	localparam logic [7:0]  RST_WAKE_CFG  = 8'h78;
	localparam logic [15:0] RST_THR_PARAM = 16'h001B;
	localparam logic [15:0] RST_GAIN_CAL  = 16'h30D4;
	localparam logic [7:0]  RST_SAMPLE_INTERVAL_COUNT   = 8'h10;
	localparam logic [15:0] RST_SLEEP_V   = 16'h1770;
	localparam logic [15:0] RST_NULL_CURR = 16'h000A;
	localparam logic [7:0]  RST_PERSIST   = 8'h02;
	localparam logic [15:0] RST_OWN_DRAIN = 16'h004D;
	localparam logic [7:0]  SAMPLE_INTERVAL_COUNT_MIN   = 8'h02;

	localparam int GAIN_SHIFT = 14;
	localparam int NUM_CELLS  = 4;

	localparam int  PERIOD_MS     = 500;
	localparam int  CLK_KHZ       = 50000;
	localparam int  PERIOD_CYCLES = PERIOD_MS * CLK_KHZ;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### battery_power_mode_control.sv
// Purpose: Run/Sample/SLEEP mode control, measurement schedule, charge
//          state and per-period charge accounting
// Assumes: Converter results arrive as signed mA and mV with a valid pulse
// Notes:   Registers on AXI4-Lite; period length is a parameter
//
// How it works
// - Threshold is threshold param times gain cal shifted down by 16384.
// - Run mode entered after two consecutive over-threshold currents.
// - Run exits only to Sample, after two consecutive under-threshold.
// - In Run every period requests current and voltage.
// - One cell input measured per measurement, stepping round the cells.
// - Sample may go to Run or to SLEEP.
// - Sample measures once every sample interval periods, minimum two.
// - Sample still runs calculation and bus service each period.
// - SLEEP only from Sample when top cell voltage below sleep limit.
// - Low voltage with current over threshold does not enter SLEEP.
// - SLEEP exits only to Run on an enabled wake condition.
// - SLEEP stops measuring, calculating, display and bus service.
// - Wake bits 6 pin, 5 bus, 4 current, 3 voltage enable sources.
// - Bits 2:0 select wake voltage from eight fixed levels.
// - Charge-gain only when charge current above floor, else loss.
// - State change after condition persists the persistence count.
// - Self-discharge subtracted in both charge states.
// - Charge change is integral minus drain, self-discharge and errors.
// - Error terms always subtracted and summed into max error.
// - Own drain is a scaled current, typical 77.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.

`timescale 1ns/1ps

module battery_power_mode_control
	import pwr_mode_pkg::*;
#(
	parameter int PERIOD_LEN = PERIOD_CYCLES
) (
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Measurement front end
	input  wire logic signed [15:0] meas_current,
	input  wire logic [15:0]        meas_voltage,
	input  wire logic               meas_valid,
	output logic                    meas_request,
	output logic [1:0]              cell_select,
	// Wake activity
	input  wire logic               pin_activity,
	input  wire logic               bus_activity,
	// Mode outputs
	output pmode_t                  power_mode,
	output logic                    calc_tick,
	output logic                    bus_service_en,
	output logic                    display_en,
	output logic                    charge_gain_state
);

	logic [7:0]         wake_configuration_r;
	logic [15:0]        thr_param_r, gain_cal_r, sleep_v_r, null_curr_r;
	logic [7:0]         sample_interval_count_r, persist_r;
	logic [15:0]        curr_err_r, sd_err_r, own_drain_r, sd_pct_r;
	logic [15:0]        fcc_r;
	logic [31:0]        capacity_r, max_error_r;
	pmode_t             mode_r;
	logic [31:0]        period_cnt_r;
	logic               period_tick;
	logic [7:0]         samp_cnt_r;
	logic [1:0]         over_cnt_r, under_cnt_r;
	logic [7:0]         persist_cnt_r;
	logic [1:0]         cell_r;
	logic [15:0]        cur_mag;
	logic [15:0]        threshold;
	logic [15:0]        wake_mv;
	logic               over_thr, wake_hit;
	logic               aw_done_r, w_done_r;
	logic [7:0]         aw_addr_r;
	logic [31:0]        w_data_r;
	logic signed [31:0] dq_delta;
	logic [31:0]        err_sum;
	logic [31:0]        sd_loss;

	// Threshold in mA from parameter and gain calibration
	function automatic logic [15:0] scale_thr(input logic [15:0] p,
		input logic [15:0] g);
		logic [31:0] prod;
		prod = 32'(p) * 32'(g);
		return prod[GAIN_SHIFT +: 16];
	endfunction

	function automatic logic [15:0] wake_level(input logic [2:0] sel);
		case (sel)
			3'h0: wake_level = 16'h1900;
			3'h1: wake_level = 16'h1A04;
			3'h2: wake_level = 16'h22B0;
			3'h3: wake_level = 16'h2580;
			3'h4: wake_level = 16'h2706;
			3'h5: wake_level = 16'h2B5C;
			3'h6: wake_level = 16'h3200;
			default: wake_level = 16'h33F4;
		endcase
	endfunction

	assign threshold = scale_thr(thr_param_r, gain_cal_r);
	assign cur_mag   = meas_current[15] ? 16'(-meas_current)
		: 16'(meas_current);
	assign over_thr  = cur_mag > threshold;
	assign wake_mv   = wake_level(wake_configuration_r[2:0]);

	// Any enabled source wakes; voltage compares any valid reading, whatever the cell
	assign wake_hit =
		(wake_configuration_r[WAKE_PIN_BIT] && pin_activity) ||
		(wake_configuration_r[WAKE_BUS_BIT] && bus_activity) ||
		(wake_configuration_r[WAKE_CURR_BIT] && meas_valid && over_thr) ||
		(wake_configuration_r[WAKE_VOLT_BIT] && meas_valid &&
			meas_voltage >= wake_mv);

	// Period timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_cnt_r <= 32'h0;
		end else if (period_cnt_r == 32'(PERIOD_LEN - 1)) begin
			period_cnt_r <= 32'h0;
		end else begin
			period_cnt_r <= period_cnt_r + 32'h1;
		end
	end
	assign period_tick = period_cnt_r == 32'(PERIOD_LEN - 1);

	// Sample-interval counter; measure on its wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samp_cnt_r <= 8'h0;
		end else if (period_tick) begin
			if (mode_r != MODE_SAMPLE ||
				samp_cnt_r >= sample_interval_count_r - 8'h1) begin
				samp_cnt_r <= 8'h0;
			end else begin
				samp_cnt_r <= samp_cnt_r + 8'h1;
			end
		end
	end

	// Run every period, Sample every interval, SLEEP never
	assign meas_request = period_tick && (mode_r == MODE_RUN ||
		(mode_r == MODE_SAMPLE && samp_cnt_r == 8'h0));
	assign calc_tick      = period_tick && mode_r != MODE_SLEEP;
	assign bus_service_en = mode_r != MODE_SLEEP;
	assign display_en     = mode_r != MODE_SLEEP;
	assign cell_select    = cell_r;
	assign power_mode     = mode_r;

	// One cell per measurement, stepping round
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cell_r <= 2'h0;
		end else if (meas_request) begin
			cell_r <= (cell_r == 2'(NUM_CELLS - 1)) ? 2'h0
				: cell_r + 2'h1;
		end
	end

	// Consecutive qualification counters
	always_ff @(posedge aclk) begin
		if (!aresetn || mode_r == MODE_SLEEP) begin
			over_cnt_r  <= 2'h0;
			under_cnt_r <= 2'h0;
		end else if (meas_valid) begin
			over_cnt_r  <= over_thr ? (over_cnt_r == 2'h2 ? 2'h2
				: over_cnt_r + 2'h1) : 2'h0;
			under_cnt_r <= !over_thr ? (under_cnt_r == 2'h2 ? 2'h2
				: under_cnt_r + 2'h1) : 2'h0;
		end
	end

	// Mode machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= MODE_SAMPLE;
		end else begin
			case (mode_r)
				MODE_SAMPLE: begin
					if (meas_valid && over_thr && over_cnt_r == 2'h1) begin
						mode_r <= MODE_RUN;
					end else if (meas_valid && !over_thr &&
						cell_r == 2'h1 && meas_voltage < sleep_v_r) begin
						// Top cell reading only; current gate keeps Run
						mode_r <= MODE_SLEEP;
					end
				end
				MODE_RUN: begin
					if (meas_valid && !over_thr && under_cnt_r == 2'h1) begin
						mode_r <= MODE_SAMPLE;
					end
				end
				MODE_SLEEP: begin
					if (wake_hit) begin
						mode_r <= MODE_RUN;
					end
				end
				default: mode_r <= MODE_SAMPLE;
			endcase
		end
	end

	// Charge-gain / charge-loss persistence
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			charge_gain_state <= 1'b0;
			persist_cnt_r     <= 8'h0;
		end else if (meas_valid && mode_r != MODE_SLEEP) begin
			if ((meas_current > $signed({1'b0, null_curr_r})) !=
				charge_gain_state) begin
				if (persist_cnt_r + 8'h1 >= persist_r) begin
					charge_gain_state <= !charge_gain_state;
					persist_cnt_r     <= 8'h0;
				end else begin
					persist_cnt_r <= persist_cnt_r + 8'h1;
				end
			end else begin
				persist_cnt_r <= 8'h0;
			end
		end
	end

	// Per-period charge change; drain scaled per period in mA units
	assign sd_loss  = (32'(sd_pct_r) * 32'(fcc_r)) >> 16;
	assign err_sum  = 32'(curr_err_r) + 32'(sd_err_r);
	assign dq_delta = 32'(meas_current) - 32'(own_drain_r)
		- $signed(sd_loss) - $signed(err_sum);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capacity_r  <= 32'h0;
			max_error_r <= 32'h0;
		end else if (calc_tick) begin
			capacity_r  <= capacity_r + 32'(dq_delta);
			max_error_r <= max_error_r + err_sum;
		end
	end

	// AXI4-Lite write: address and data in either order
	assign s_axi_awready = !aw_done_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_done_r && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_done_r <= 1'b0;
			w_done_r  <= 1'b0;
			aw_addr_r <= 8'h0;
			w_data_r  <= 32'h0;
		end else if (aw_done_r && w_done_r) begin
			aw_done_r <= 1'b0;
			w_done_r  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done_r <= 1'b1;
				w_data_r <= s_axi_wdata;
			end
		end
	end

	// Register writes; strobe bit 0 alone gates the whole register for simplicity
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_configuration_r <= RST_WAKE_CFG;
			thr_param_r <= RST_THR_PARAM;
			gain_cal_r  <= RST_GAIN_CAL;
			sample_interval_count_r   <= RST_SAMPLE_INTERVAL_COUNT;
			sleep_v_r   <= RST_SLEEP_V;
			null_curr_r <= RST_NULL_CURR;
			persist_r   <= RST_PERSIST;
			curr_err_r  <= 16'h0;
			sd_err_r    <= 16'h0;
			own_drain_r <= RST_OWN_DRAIN;
			sd_pct_r    <= 16'h0;
			fcc_r       <= 16'h0;
		end else if (aw_done_r && w_done_r && s_axi_wstrb[0]) begin
			case (aw_addr_r)
				OFF_WAKE_CFG:  wake_configuration_r <= w_data_r[7:0];
				OFF_THR_PARAM: thr_param_r <= w_data_r[15:0];
				OFF_GAIN_CAL:  gain_cal_r  <= w_data_r[15:0];
				// Below two is raised to two; one would measure every period
				OFF_SAMPLE_INTERVAL_COUNT:   sample_interval_count_r <= (w_data_r[7:0] < SAMPLE_INTERVAL_COUNT_MIN)
					? SAMPLE_INTERVAL_COUNT_MIN : w_data_r[7:0];
				OFF_SLEEP_V:   sleep_v_r   <= w_data_r[15:0];
				OFF_NULL_CURR: null_curr_r <= w_data_r[15:0];
				OFF_PERSIST:   persist_r   <= w_data_r[7:0];
				OFF_CURR_ERR:  curr_err_r  <= w_data_r[15:0];
				OFF_SD_ERR:    sd_err_r    <= w_data_r[15:0];
				OFF_OWN_DRAIN: own_drain_r <= w_data_r[15:0];
				OFF_SD_PCT:    sd_pct_r    <= w_data_r[15:0];
				OFF_FCC:       fcc_r       <= w_data_r[15:0];
				default: ;
			endcase
		end
	end

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = a[1:0] == 2'b00 && a <= OFF_MAX_ERROR;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (aw_done_r && w_done_r) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (known_addr(aw_addr_r) &&
				aw_addr_r < OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= known_addr(s_axi_araddr) ? RESP_OKAY
				: RESP_SLVERR;
			case (s_axi_araddr)
				OFF_WAKE_CFG:  s_axi_rdata <= {24'h0, wake_configuration_r};
				OFF_THR_PARAM: s_axi_rdata <= {16'h0, thr_param_r};
				OFF_GAIN_CAL:  s_axi_rdata <= {16'h0, gain_cal_r};
				OFF_SAMPLE_INTERVAL_COUNT:   s_axi_rdata <= {24'h0, sample_interval_count_r};
				OFF_SLEEP_V:   s_axi_rdata <= {16'h0, sleep_v_r};
				OFF_NULL_CURR: s_axi_rdata <= {16'h0, null_curr_r};
				OFF_PERSIST:   s_axi_rdata <= {24'h0, persist_r};
				OFF_CURR_ERR:  s_axi_rdata <= {16'h0, curr_err_r};
				OFF_SD_ERR:    s_axi_rdata <= {16'h0, sd_err_r};
				OFF_OWN_DRAIN: s_axi_rdata <= {16'h0, own_drain_r};
				OFF_SD_PCT:    s_axi_rdata <= {16'h0, sd_pct_r};
				OFF_FCC:       s_axi_rdata <= {16'h0, fcc_r};
				OFF_STATUS:    s_axi_rdata <= {27'h0, charge_gain_state,
					cell_r, mode_r};
				OFF_CAPACITY:  s_axi_rdata <= capacity_r;
				OFF_MAX_ERROR: s_axi_rdata <= max_error_r;
				default:       s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Assertions
	property p_run_entry;
		@(posedge aclk) disable iff (!aresetn)
		$changed(mode_r) && mode_r == MODE_RUN &&
			$past(mode_r) == MODE_SAMPLE |->
			$past(over_cnt_r) == 2'h1 && $past(over_thr) &&
			$past(meas_valid);
	endproperty
	a_run_entry: assert property (p_run_entry)
		else $error("run entered without two over-threshold results");

	property p_run_exit;
		@(posedge aclk) disable iff (!aresetn)
		$past(mode_r) == MODE_RUN |-> mode_r != MODE_SLEEP;
	endproperty
	a_run_exit: assert property (p_run_exit)
		else $error("run moved directly to sleep");

	property p_sleep_entry;
		@(posedge aclk) disable iff (!aresetn)
		$changed(mode_r) && mode_r == MODE_SLEEP |->
			$past(mode_r) == MODE_SAMPLE && !$past(over_thr) &&
			$past(meas_voltage) < $past(sleep_v_r);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep entered illegally");

	property p_sleep_exit;
		@(posedge aclk) disable iff (!aresetn)
		$past(mode_r) == MODE_SLEEP && mode_r != MODE_SLEEP |->
			mode_r == MODE_RUN && $past(wake_hit);
	endproperty
	a_sleep_exit: assert property (p_sleep_exit)
		else $error("sleep left without wake");

	property p_sleep_quiet;
		@(posedge aclk) disable iff (!aresetn)
		mode_r == MODE_SLEEP |-> !meas_request && !calc_tick &&
			!bus_service_en && !display_en;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("activity during sleep");

	property p_run_meas;
		@(posedge aclk) disable iff (!aresetn)
		period_tick && mode_r == MODE_RUN |-> meas_request;
	endproperty
	a_run_meas: assert property (p_run_meas)
		else $error("run period without measurement");

	property p_sample_skip;
		@(posedge aclk) disable iff (!aresetn)
		meas_request && mode_r == MODE_SAMPLE |-> samp_cnt_r == 8'h0;
	endproperty
	a_sample_skip: assert property (p_sample_skip)
		else $error("sample measured off interval");

	property p_sample_interval_count_min;
		@(posedge aclk) disable iff (!aresetn)
		sample_interval_count_r >= SAMPLE_INTERVAL_COUNT_MIN;
	endproperty
	a_sample_interval_count_min: assert property (p_sample_interval_count_min)
		else $error("sample interval below two");

	property p_cell_step;
		@(posedge aclk) disable iff (!aresetn)
		meas_request |=> cell_r == $past(cell_r) + 2'h1;
	endproperty
	a_cell_step: assert property (p_cell_step)
		else $error("cell input did not step");

	property p_err_grow;
		@(posedge aclk) disable iff (!aresetn)
		calc_tick |=> max_error_r == $past(max_error_r) + $past(err_sum);
	endproperty
	a_err_grow: assert property (p_err_grow)
		else $error("max error not accumulated");

endmodule

// ### meas_front_end_model.sv
// Purpose: Measurement front end stand-in for the mode controller
// Assumes: One result per request after a fixed latency
// Notes:   Result lines toggle whenever no result is presented
`timescale 1ns/1ps

module meas_front_end_model #(
	parameter int LAT = 3
) (
	// Clock
	input  wire logic               aclk,
	// Device side
	input  wire logic               meas_request,
	input  wire logic [1:0]         cell_select,
	output logic signed [15:0]      meas_current,
	output logic [15:0]             meas_voltage,
	output logic                    meas_valid,
	// Bench control
	input  wire logic signed [15:0] cur_set,
	input  wire logic [15:0]        volt_set,
	input  wire logic               inject
);
	int   cnt;
	logic top;

	initial begin
		cnt = 0;
		top = 1'b0;
		meas_valid = 1'b0;
		meas_current = 16'h0000;
		meas_voltage = 16'h0000;
	end

	always @(posedge aclk) begin
		meas_valid <= 1'b0;
		// Stale data is not held, so a late sample shows garbage
		meas_current <= ~meas_current;
		meas_voltage <= ~meas_voltage;
		if (meas_request) begin
			cnt <= LAT;
			top <= (cell_select == 2'h0);
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1 || inject) begin
			cnt <= 0;
			meas_valid <= 1'b1;
			meas_current <= cur_set;
			// Lower cells read low, so only the controller's top-cell gate keeps them from causing sleep
			meas_voltage <= (top || inject) ? volt_set : 16'h0BB8;
		end
	end
endmodule

// ### battery_power_mode_control_tb.sv
// Purpose: Self-checking bench for the power-mode controller
// Assumes: Short period parameter; positive current means charging
// Notes:   Wake voltage is fed by injected results while sleeping
`timescale 1ns/1ps

module battery_power_mode_control_tb
	import pwr_mode_pkg::*;
;
	localparam int P = 20;
	localparam int THR = (int'(RST_THR_PARAM) * int'(RST_GAIN_CAL)) / 16384;

	logic               aclk, aresetn;
	logic [7:0]         s_axi_awaddr, s_axi_araddr;
	logic [31:0]        s_axi_wdata, s_axi_rdata;
	logic [3:0]         s_axi_wstrb;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic               s_axi_rready;
	logic [1:0]         s_axi_bresp, s_axi_rresp, cell_select, c;
	logic signed [15:0] meas_current, cur_set;
	logic [15:0]        meas_voltage, volt_set;
	logic               meas_valid, meas_request, inject;
	logic               pin_activity, bus_activity, calc_tick;
	logic               bus_service_en, display_en, charge_gain_state;
	pmode_t             power_mode, last_mode;
	logic               sleep_seen, bad_step;
	logic [31:0]        a, b;
	logic [1:0]         r;
	int                 err_total, compares, i, n;
	logic [15:0]        lvl [8] = '{16'h1900, 16'h1A04, 16'h22B0,
		16'h2580, 16'h2706, 16'h2B5C, 16'h3200, 16'h33F4};

	battery_power_mode_control #(.PERIOD_LEN(P)) i_battery_power_mode_control (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .meas_current, .meas_voltage,
		.meas_valid, .meas_request, .cell_select, .pin_activity,
		.bus_activity, .power_mode, .calc_tick, .bus_service_en,
		.display_en, .charge_gain_state);

	meas_front_end_model #(.LAT(3)) i_meas_front_end_model (
		.aclk, .meas_request, .cell_select, .meas_current,
		.meas_voltage, .meas_valid, .cur_set, .volt_set, .inject);

	always #10 aclk = ~aclk;

	// Mode steps are judged edge by edge, so brief detours are caught too
	always @(posedge aclk) begin
		last_mode <= power_mode;
		if (power_mode === MODE_SLEEP) sleep_seen <= 1'b1;
		if (aresetn && power_mode !== last_mode) begin
			if (power_mode === MODE_SLEEP && last_mode !== MODE_SAMPLE)
				bad_step <= 1'b1;
			if (last_mode === MODE_SLEEP && power_mode !== MODE_RUN)
				bad_step <= 1'b1;
		end
	end

	task automatic wrap_up();
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic hang(input string nm);
		chk(nm, 32'h1, 32'h0);
		wrap_up();
	endtask

	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] er);
		int  k;
		logic aw_ok, w_ok, aw_hs, w_hs, b_hs;
		logic [1:0] br;
		k = 0;
		b_hs = 1'b0;
		br = 2'b00;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Handshakes are judged on settled values ahead of the edge
		do begin
			@(negedge aclk);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge aclk);
			k++;
			if (aw_hs) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (w_hs) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok && b_hs) && k < 50);
		if (k >= 50) hang("write answer");
		chk("bresp", {30'h0, er}, {30'h0, br});
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d,
		output logic [1:0] rr);
		int k;
		logic ar_hs, r_hs;
		k = 0;
		r_hs = 1'b0;
		d = 32'h0;
		rr = 2'b00;
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rvalid;
			d = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			k++;
			if (ar_hs) s_axi_arvalid <= 1'b0;
		end while (!r_hs && k < 50);
		if (k >= 50) hang("read answer");
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] ed,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  rr;
		axi_rd(ad, d, rr);
		chk("rdata", ed, d);
		chk("rresp", {30'h0, er}, {30'h0, rr});
	endtask

	task automatic wait_valid();
		int k;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (!meas_valid && k < 2000);
		if (k >= 2000) hang("result");
		tick(3);
	endtask

	task automatic gap(input bit tk, input int e);
		int k;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (!(tk ? calc_tick : meas_request) && k < 2000);
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (!(tk ? calc_tick : meas_request) && k < 2000);
		chk("spacing", e, k);
	endtask

	task automatic wait_mode(input pmode_t m);
		int k;
		k = 0;
		while (power_mode !== m && k < 3000) begin
			@(posedge aclk);
			k++;
		end
		chk("mode", m, power_mode);
	endtask

	initial begin
		repeat (100000) @(posedge aclk);
		hang("run length");
	end

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, pin_activity, bus_activity} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, inject, bad_step} = '0;
		{err_total, compares, sleep_seen} = '0;
		s_axi_wstrb = 4'hF;
		cur_set = 16'h000F;
		volt_set = 16'h1F40;
		tick(4);
		aresetn <= 1'b1;
		tick(1);
		chk("mode", MODE_SAMPLE, power_mode);
		rd_chk(OFF_WAKE_CFG, {24'h0, RST_WAKE_CFG}, RESP_OKAY);
		rd_chk(OFF_THR_PARAM, {16'h0, RST_THR_PARAM}, RESP_OKAY);
		rd_chk(OFF_GAIN_CAL, {16'h0, RST_GAIN_CAL}, RESP_OKAY);
		rd_chk(OFF_SLEEP_V, {16'h0, RST_SLEEP_V}, RESP_OKAY);
		rd_chk(OFF_NULL_CURR, {16'h0, RST_NULL_CURR}, RESP_OKAY);
		rd_chk(OFF_PERSIST, {24'h0, RST_PERSIST}, RESP_OKAY);
		rd_chk(OFF_OWN_DRAIN, {16'h0, RST_OWN_DRAIN}, RESP_OKAY);
		rd_chk(8'h3C, 32'h0, RESP_SLVERR);
		axi_wr(OFF_STATUS, 32'h0, RESP_SLVERR);
		axi_wr(OFF_SAMPLE_INTERVAL_COUNT, 32'h1, RESP_OKAY);
		rd_chk(OFF_SAMPLE_INTERVAL_COUNT, {24'h0, SAMPLE_INTERVAL_COUNT_MIN}, RESP_OKAY);
		gap(1'b0, 2 * P);
		gap(1'b1, P);
		cur_set <= 16'(THR);
		wait_valid();
		wait_valid();
		chk("mode", MODE_SAMPLE, power_mode);
		cur_set <= 16'(THR + 1);
		wait_valid();
		chk("mode", MODE_SAMPLE, power_mode);
		wait_valid();
		chk("mode", MODE_RUN, power_mode);
		gap(1'b0, P);
		c = cell_select;
		for (i = 0; i < 4; i++) begin
			wait_valid();
			chk("cell", 2'(c + 2'h1), cell_select);
			c = cell_select;
		end
		cur_set <= 16'(-(THR + 1));
		wait_valid();
		chk("charge state", 32'h1, charge_gain_state);
		wait_valid();
		chk("charge state", 32'h0, charge_gain_state);
		chk("mode", MODE_RUN, power_mode);
		cur_set <= 16'(THR + 1);
		wait_valid();
		chk("charge state", 32'h0, charge_gain_state);
		wait_valid();
		chk("charge state", 32'h1, charge_gain_state);
		cur_set <= 16'(THR);
		wait_valid();
		cur_set <= 16'(THR + 1);
		wait_valid();
		cur_set <= 16'(THR);
		wait_valid();
		chk("mode", MODE_RUN, power_mode);
		wait_valid();
		chk("mode", MODE_SAMPLE, power_mode);
		chk("slept", 32'h0, sleep_seen);
		axi_wr(OFF_WAKE_CFG, 32'h20, RESP_OKAY);
		volt_set <= 16'h1388;
		cur_set <= 16'(THR + 1);
		for (i = 0; i < 6; i++) wait_valid();
		chk("slept", 32'h0, sleep_seen);
		cur_set <= 16'(THR);
		wait_mode(MODE_SLEEP);
		chk("bus service", 32'h0, bus_service_en);
		chk("display", 32'h0, display_en);
		n = 0;
		repeat (3 * P) begin
			@(posedge aclk);
			if (meas_request || calc_tick) n++;
		end
		chk("sleep activity", 32'h0, n);
		pin_activity <= 1'b1;
		tick(20);
		chk("mode", MODE_SLEEP, power_mode);
		pin_activity <= 1'b0;
		bus_activity <= 1'b1;
		wait_mode(MODE_RUN);
		bus_activity <= 1'b0;
		volt_set <= 16'h1F40;
		for (i = 0; i < 8; i++) begin
			axi_wr(OFF_WAKE_CFG, 32'h08 | i, RESP_OKAY);
			volt_set <= 16'h1388;
			wait_mode(MODE_SLEEP);
			volt_set <= lvl[i] - 16'h000A;
			inject <= 1'b1;
			tick(1);
			inject <= 1'b0;
			tick(6);
			chk("mode", MODE_SLEEP, power_mode);
			volt_set <= lvl[i] + 16'h000A;
			inject <= 1'b1;
			tick(1);
			inject <= 1'b0;
			tick(6);
			chk("mode", MODE_RUN, power_mode);
		end
		axi_wr(OFF_CURR_ERR, 32'h5, RESP_OKAY);
		axi_rd(OFF_MAX_ERROR, a, r);
		tick(3 * P);
		axi_rd(OFF_MAX_ERROR, b, r);
		chk("max error grows", 32'h1, {31'h0, b > a});
		chk("mode steps", 32'h0, bad_step);
		wrap_up();
	end
endmodule
